// ---- core/dsa_consts.svh ----
/*
  constants for the data space access unit: address map, region sizes,
  lane positions and reset values. assumes inclusion by bare name.
*/
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH

`define DSA_NEAR_LAST 16'h1fff
`define DSA_NEAR_BITS 13
`define DSA_SFR_LAST 16'h07ff
`define DSA_REGION_SHIFT 5
`define DSA_REGION_COUNT 64
`define DSA_BYTE_STEP 16'h0001
`define DSA_WORD_STEP 16'h0002
`define DSA_SIGN_BIT 7
`define DSA_ZERO_WORD 16'h0000
`define DSA_ZERO_BYTE 8'h00
`define DSA_MEM_WORDS 4096
`define DSA_MEM_AW 12

`endif

// ---- core/dsa_pkg.sv ----
/*
  types for the data space access unit.
  assumes the consts header is compiled alongside.
*/
package dsa_pkg;

  // access request from the core load/store path
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic direct;
    logic mov_instr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dsa_req_t;

  // extend operation applied to a working register value
  typedef enum logic [1:0] {
    DSA_EXT_NONE,
    DSA_EXT_SIGN,
    DSA_EXT_ZERO,
    DSA_EXT_BYTE_LOAD
  } dsa_ext_t;

  typedef enum logic [1:0] {
    DSA_IDLE,
    DSA_DONE,
    DSA_TRAP
  } dsa_state_t;

endpackage

// ---- core/dsa_byte_bank.sv ----
/*
  one byte-wide half of the data array, with its own write strobe.
  assumes word index shared with the twin half.
*/
`timescale 1ns/1ps
`include "dsa_consts.svh"

module dsa_byte_bank (
  // clock
  input wire logic clock,
  // access
  input wire logic [`DSA_MEM_AW-1:0] index,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:`DSA_MEM_WORDS-1];

  // synchronous write, registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[index] <= wdata;
    end
    rdata <= mem[index];
  end

endmodule

// ---- core/dsa_access_unit.sv ----
/*
  data space access unit: address stepping, byte lane select, split byte
  write strobes, misalignment trap, near/special region decode, extends.
  assumes the core holds a request for one cycle; read answers land two cycles
  later. special region contents live outside; this unit only decodes it.
*/
`timescale 1ns/1ps
`include "dsa_consts.svh"

module dsa_access_unit #(
  parameter logic [`DSA_REGION_COUNT-1:0] REGION_MAP = 64'hffff_ffff_ffff_ffff
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request from core
  input wire dsa_pkg::dsa_req_t req,
  input wire logic [12:0] near_field,
  // post increment of pointer register
  input wire logic [15:0] source_work_reg,
  input wire logic post_inc,
  // working register extension path
  input wire logic [15:0] work_reg_old,
  input wire dsa_pkg::dsa_ext_t ext_op,
  // special region read data from peripherals
  input wire logic [15:0] sfr_rdata,
  // outputs
  output logic [15:0] ptr_next,
  output logic [15:0] work_reg_new,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic addr_trap,
  output logic sfr_sel,
  output logic [1:0] sfr_wstrobe,
  output logic [15:0] sfr_wdata,
  output logic [15:0] sfr_addr,
  output logic access_fault
);

  // ------------------------------------------------------------------
  // address formation and decode
  // ------------------------------------------------------------------
  logic [15:0] effective_addr;
  logic misaligned;
  logic in_sfr;
  logic in_near;
  logic region_live;
  logic go;
  logic [1:0] strobe;

  // direct near form zero-extends its 13-bit field
  always_comb begin
    if (req.direct && !req.mov_instr) begin
      effective_addr = {3'h0, near_field};
    end else begin
      effective_addr = req.addr;
    end
  end

  assign misaligned = req.valid && req.word && effective_addr[0];
  assign in_near = effective_addr <= `DSA_NEAR_LAST;
  assign in_sfr = effective_addr <= `DSA_SFR_LAST;
  // one map bit per 32-byte block
  assign region_live = REGION_MAP[effective_addr[10:`DSA_REGION_SHIFT]];
  assign go = req.valid && !misaligned;

  // byte lane strobes; word writes use both halves
  always_comb begin
    if (!req.write || misaligned) begin
      strobe = 2'h0;
    end else if (req.word) begin
      strobe = 2'h3;
    end else begin
      strobe = effective_addr[0] ? 2'h2 : 2'h1;
    end
  end

  // byte writes copy the low data byte onto both lanes
  logic [15:0] lane_wdata;
  assign lane_wdata = req.word ? req.wdata : {req.wdata[7:0], req.wdata[7:0]};

  // ------------------------------------------------------------------
  // data array: two byte halves sharing the word index
  // ------------------------------------------------------------------
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic mem_go;
  assign mem_go = go && !in_sfr;

  dsa_byte_bank u_lo (
    .clock(clock),
    .index(effective_addr[`DSA_MEM_AW:1]),
    .wr_en(mem_go && strobe[0]),
    .wdata(lane_wdata[7:0]),
    .rdata(lo_q)
  );

  dsa_byte_bank u_hi (
    .clock(clock),
    .index(effective_addr[`DSA_MEM_AW:1]),
    .wr_en(mem_go && strobe[1]),
    .wdata(lane_wdata[15:8]),
    .rdata(hi_q)
  );

  // ------------------------------------------------------------------
  // special region port, registered
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sfr_sel <= 1'b0;
      sfr_wstrobe <= 2'h0;
      sfr_wdata <= `DSA_ZERO_WORD;
      sfr_addr <= `DSA_ZERO_WORD;
    end else begin
      // misaligned reads still reach the region; strobe is already zero then
      sfr_sel <= req.valid && in_sfr && region_live;
      sfr_wstrobe <= (req.valid && in_sfr && region_live) ? strobe : 2'h0;
      sfr_wdata <= lane_wdata;
      sfr_addr <= {effective_addr[15:1], 1'b0};
    end
  end

  // ------------------------------------------------------------------
  // pipeline of the read side into the answer cycle
  // ------------------------------------------------------------------
  logic p_read;
  logic p_word;
  logic p_odd;
  logic p_sfr;
  logic p_live;

  // capture attributes needed when the data returns
  always_ff @(posedge clock) begin
    if (rst) begin
      p_read <= 1'b0;
      p_word <= 1'b0;
      p_odd <= 1'b0;
      p_sfr <= 1'b0;
      p_live <= 1'b0;
    end else begin
      // misaligned reads still complete with data
      p_read <= req.valid && !req.write;
      p_word <= req.word;
      p_odd <= effective_addr[0];
      p_sfr <= in_sfr;
      p_live <= region_live;
    end
  end

  // word image from the selected source; holes read zero
  logic [15:0] word_img;
  always_comb begin
    if (!p_sfr) begin
      word_img = {hi_q, lo_q};
    end else if (p_live) begin
      word_img = sfr_rdata;
    end else begin
      word_img = `DSA_ZERO_WORD;
    end
  end

  // whole word fetched, selected byte placed on the low lane
  logic [15:0] next_rdata;
  always_comb begin
    if (p_word) begin
      next_rdata = word_img;
    end else if (p_odd) begin
      next_rdata = {`DSA_ZERO_BYTE, word_img[15:8]};
    end else begin
      next_rdata = {`DSA_ZERO_BYTE, word_img[7:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= `DSA_ZERO_WORD;
      rvalid <= 1'b0;
    end else begin
      rdata <= p_read ? next_rdata : `DSA_ZERO_WORD;
      rvalid <= p_read;
    end
  end

  // ------------------------------------------------------------------
  // trap sequencing: flagged with the access, taken after it
  // ------------------------------------------------------------------
  dsa_pkg::dsa_state_t state;
  logic trap_pend;

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= dsa_pkg::DSA_IDLE;
      trap_pend <= 1'b0;
    end else begin
      case (state)
        dsa_pkg::DSA_IDLE: begin
          if (misaligned) begin
            state <= dsa_pkg::DSA_DONE;
            trap_pend <= 1'b1;
          end
        end
        dsa_pkg::DSA_DONE: begin
          // instruction finishes here; trap follows next
          state <= dsa_pkg::DSA_TRAP;
        end
        default: begin
          // trap cycle: a fresh odd word access starts its own sequence
          state <= misaligned ? dsa_pkg::DSA_DONE : dsa_pkg::DSA_IDLE;
          trap_pend <= misaligned;
        end
      endcase
    end
  end

  // fault flag in the cycle after the access edge; trap after completion
  always_ff @(posedge clock) begin
    if (rst) begin
      access_fault <= 1'b0;
      addr_trap <= 1'b0;
    end else begin
      access_fault <= misaligned;
      addr_trap <= trap_pend && state == dsa_pkg::DSA_DONE;
    end
  end

  // ------------------------------------------------------------------
  // pointer stepping and working register extension
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ptr_next <= `DSA_ZERO_WORD;
    end else if (post_inc) begin
      ptr_next <= source_work_reg + (req.word ? `DSA_WORD_STEP : `DSA_BYTE_STEP);
    end else begin
      ptr_next <= source_work_reg;
    end
  end

  logic [15:0] next_work;
  always_comb begin
    case (ext_op)
      dsa_pkg::DSA_EXT_SIGN: begin
        next_work = {{8{work_reg_old[`DSA_SIGN_BIT]}}, work_reg_old[7:0]};
      end
      dsa_pkg::DSA_EXT_ZERO: begin
        next_work = {`DSA_ZERO_BYTE, work_reg_old[7:0]};
      end
      dsa_pkg::DSA_EXT_BYTE_LOAD: begin
        next_work = {work_reg_old[15:8], sfr_rdata[7:0]};
      end
      default: begin
        next_work = work_reg_old;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      work_reg_new <= `DSA_ZERO_WORD;
    end else begin
      work_reg_new <= next_work;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_trap_after_fault;
    @(posedge clock) disable iff (rst)
    access_fault && $past(state) != dsa_pkg::DSA_DONE |=> addr_trap;
  endproperty
  a_trap_after_fault: assert property (p_trap_after_fault) else $error("trap missing");
  property p_odd_word_faults;
    @(posedge clock) disable iff (rst)
    req.valid && req.word && effective_addr[0] |=> access_fault;
  endproperty
  a_odd_word_faults: assert property (p_odd_word_faults) else $error("no fault");
  property p_no_write_misaligned;
    @(posedge clock) disable iff (rst)
    misaligned |-> strobe == 2'h0 ##1 sfr_wstrobe == 2'h0;
  endproperty
  a_no_write_misaligned: assert property (p_no_write_misaligned) else $error("bad write");
  property p_byte_one_half;
    @(posedge clock) disable iff (rst)
    go && req.write && !req.word |-> strobe != 2'h3;
  endproperty
  a_byte_one_half: assert property (p_byte_one_half) else $error("both halves");
  property p_step;
    @(posedge clock) disable iff (rst)
    post_inc |=> ptr_next == $past(source_work_reg) + ($past(req.word) ? 16'h0002 : 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_sign;
    @(posedge clock) disable iff (rst)
    ext_op == dsa_pkg::DSA_EXT_SIGN |=> work_reg_new[15:8] == {8{$past(work_reg_old[7])}};
  endproperty
  a_sign: assert property (p_sign) else $error("bad sign extend");
  property p_zero;
    @(posedge clock) disable iff (rst)
    ext_op == dsa_pkg::DSA_EXT_ZERO |=> work_reg_new == {8'h00, $past(work_reg_old[7:0])};
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero extend");
  property p_byte_read_low;
    @(posedge clock) disable iff (rst)
    req.valid && !req.write && !req.word |-> ##2 rvalid && rdata[15:8] == 8'h00;
  endproperty
  a_byte_read_low: assert property (p_byte_read_low) else $error("upper lane set");
  property p_hole_zero;
    @(posedge clock) disable iff (rst)
    req.valid && !req.write && in_sfr && !region_live |-> ##2 rdata == 16'h0000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("hole not zero");
  property p_direct_reach;
    @(posedge clock) disable iff (rst)
    req.valid && req.direct |-> (req.mov_instr ? effective_addr == req.addr : in_near);
  endproperty
  a_direct_reach: assert property (p_direct_reach) else $error("direct reach");

endmodule

// ---- tb/dsa_sfr_model.sv ----
/*
  peripheral register array behind the special region port of the unit.
  assumes strobe, address and data one cycle after a request; reads are
  combinational while the region is selected.
*/
`timescale 1ns/1ps

module dsa_sfr_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // special region port
  input wire logic sfr_sel,
  input wire logic [1:0] sfr_wstrobe,
  input wire logic [15:0] sfr_wdata,
  input wire logic [15:0] sfr_addr,
  output logic [15:0] sfr_rdata
);
  logic [15:0] regs [32];
  logic [15:0] last;

  // two byte halves with one shared word index, each with its own strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 16'h0000;
      end
    end else if (sfr_sel) begin
      if (sfr_wstrobe[0]) regs[sfr_addr[5:1]][7:0] <= sfr_wdata[7:0];
      if (sfr_wstrobe[1]) regs[sfr_addr[5:1]][15:8] <= sfr_wdata[15:8];
    end
  end

  // a deselected bus shows the inverse, so a stale copy is never mistaken
  always_ff @(posedge clock) begin
    if (rst) begin
      last <= 16'h0000;
    end else if (sfr_sel) begin
      last <= sfr_rdata;
    end
  end
  assign sfr_rdata = sfr_sel ? regs[sfr_addr[5:1]] : ~last;
endmodule

// ---- tb/testbench.sv ----
/*
  self-checking bench for the data space access unit.
  assumes one request every three cycles in the table, answers as handed over.
*/
`timescale 1ns/1ps

module testbench;
  typedef struct packed {
    logic wr; logic w; logic dir; logic move_instruction;
    logic [12:0] nf; logic [15:0] addr; logic [15:0] wd; logic [15:0] exp; logic flt;
  } dsa_row_t;

  localparam logic [63:0] MAP = 64'hffff_ffff_ffff_fffb; // block 2 left empty
  logic clock, rst, post_inc;
  dsa_pkg::dsa_req_t req;
  logic [12:0] near_field;
  logic [15:0] source_work_reg, work_reg_old, sfr_rdata, ptr_next, work_reg_new, rdata;
  logic [15:0] sfr_wdata, sfr_addr, ea;
  dsa_pkg::dsa_ext_t ext_op;
  logic rvalid, addr_trap, sfr_sel, access_fault, sel;
  logic [1:0] sfr_wstrobe;
  int miscompares = 0;
  int cmp_count = 0;
  dsa_row_t rows [20] = '{
    '{1,1,0,0,0,16'h0900,16'ha1b2,0,0}, '{0,0,0,0,0,16'h0900,0,16'h00b2,0},
    '{0,0,0,0,0,16'h0901,0,16'h00a1,0}, '{1,0,0,0,0,16'h0901,16'h0055,0,0},
    '{0,1,0,0,0,16'h0900,0,16'h55b2,0}, '{1,1,0,0,0,16'h0902,16'h1234,0,0},
    '{1,1,0,0,0,16'h0903,16'hffff,0,1}, '{0,1,0,0,0,16'h0902,0,16'h1234,0},
    '{0,1,0,0,0,16'h0901,0,16'h55b2,1}, '{0,1,1,0,13'h0900,16'hf900,0,16'h55b2,0},
    '{0,1,1,1,0,16'h2900,0,16'h55b2,0}, '{1,0,0,0,0,16'h0800,16'h00cc,0,0},
    '{0,0,0,0,0,16'h0800,0,16'h00cc,0}, '{1,1,0,0,0,16'h0020,16'hbeef,0,0},
    '{1,0,0,0,0,16'h0021,16'h0011,0,0}, '{0,1,0,0,0,16'h0020,0,16'h11ef,0},
    '{1,1,0,0,0,16'h0023,16'hffff,0,1}, '{0,1,0,0,0,16'h0022,0,16'h0000,0},
    '{1,1,0,0,0,16'h0040,16'h5555,0,0}, '{0,1,0,0,0,16'h0040,0,16'h0000,0}};

  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

  dsa_access_unit #(.REGION_MAP(MAP)) dsa_access_unit_inst (.clock(clock), .rst(rst),
    .req(req), .near_field(near_field), .source_work_reg(source_work_reg),
    .post_inc(post_inc), .work_reg_old(work_reg_old), .ext_op(ext_op),
    .sfr_rdata(sfr_rdata), .ptr_next(ptr_next), .work_reg_new(work_reg_new),
    .rdata(rdata), .rvalid(rvalid), .addr_trap(addr_trap), .sfr_sel(sfr_sel),
    .sfr_wstrobe(sfr_wstrobe), .sfr_wdata(sfr_wdata), .sfr_addr(sfr_addr),
    .access_fault(access_fault));
  dsa_sfr_model dsa_sfr_model_inst (.clock(clock), .rst(rst), .sfr_sel(sfr_sel),
    .sfr_wstrobe(sfr_wstrobe), .sfr_wdata(sfr_wdata), .sfr_addr(sfr_addr),
    .sfr_rdata(sfr_rdata));

  // 50 MHz core clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one request held for exactly one edge, pointer stepping alongside
  task automatic issue(input dsa_row_t r);
    @(posedge clock);
    req <= '{valid:1'b1, write:r.wr, word:r.w, direct:r.dir, mov_instr:r.move_instruction,
             addr:r.addr, wdata:r.wd};
    near_field <= r.nf;
    source_work_reg <= r.addr;
    post_inc <= 1'b1;
    @(posedge clock);
    req.valid <= 1'b0;
  endtask

  // extension path: result one cycle after the operands are taken
  task automatic ext(input dsa_pkg::dsa_ext_t op, input logic [15:0] v);
    @(posedge clock);
    ext_op <= op;
    work_reg_old <= v;
    @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    near_field = 13'h0000;
    source_work_reg = 16'h0000;
    post_inc = 1'b0;
    work_reg_old = 16'h0000;
    ext_op = dsa_pkg::DSA_EXT_NONE;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK({rvalid, addr_trap, access_fault, sfr_sel}, 4'h0)
    foreach (rows[i]) begin
      ea = (rows[i].dir && !rows[i].move_instruction) ? {3'h0, rows[i].nf} : rows[i].addr;
      sel = (ea <= 16'h07ff) && MAP[ea[10:5]];
      issue(rows[i]);
      #1;
      `CHK(access_fault, rows[i].flt)
      `CHK(ptr_next, rows[i].addr + (rows[i].w ? 16'h0002 : 16'h0001))
      `CHK(sfr_sel, sel)
      `CHK(sfr_addr, {ea[15:1], 1'b0})
      if (rows[i].wr && rows[i].w) `CHK(sfr_wdata, rows[i].wd)
      if (rows[i].wr && !rows[i].w) `CHK(sfr_wdata[ea[0]*8 +: 8], rows[i].wd[7:0])
      `CHK(sfr_wstrobe, (rows[i].wr && !rows[i].flt && sel) ?
        (rows[i].w ? 2'b11 : (ea[0] ? 2'b10 : 2'b01)) : 2'b00)
      @(posedge clock);
      #1;
      `CHK(rvalid, !rows[i].wr)
      if (!rows[i].wr) `CHK(rdata, rows[i].exp)
      `CHK(addr_trap, rows[i].flt)
    end
    // byte writes two cycles apart into both halves of one word
    issue('{1,0,0,0,0,16'h0a00,16'h0034,0,0});
    issue('{1,0,0,0,0,16'h0a01,16'h0012,0,0});
    issue('{0,1,0,0,0,16'h0a00,0,0,0});
    @(posedge clock);
    #1;
    `CHK(rdata, 16'h1234)
    ext(dsa_pkg::DSA_EXT_SIGN, 16'h1280);
    `CHK(work_reg_new, 16'hff80)
    ext(dsa_pkg::DSA_EXT_SIGN, 16'hab7f);
    `CHK(work_reg_new, 16'h007f)
    ext(dsa_pkg::DSA_EXT_ZERO, 16'hab80);
    `CHK(work_reg_new, 16'h0080)
    ext(dsa_pkg::DSA_EXT_BYTE_LOAD, 16'hc3a5);
    `CHK(work_reg_new, {8'hc3, sfr_rdata[7:0]})
    ext(dsa_pkg::DSA_EXT_NONE, 16'h5a5a);
    `CHK(work_reg_new, 16'h5a5a)
    // without post increment the pointer passes through unchanged
    @(posedge clock);
    post_inc <= 1'b0;
    @(posedge clock);
    #1;
    `CHK(ptr_next, 16'h0a00)
    // misaligned read of a live special word still returns the even word
    issue('{0,1,0,0,0,16'h0021,0,0,1});
    @(posedge clock);
    #1;
    `CHK({addr_trap, rdata}, {1'b1, 16'h11ef})
    // reset landing while a trap is still pending must swallow it
    issue('{0,1,0,0,0,16'h0905,0,0,1});
    rst <= 1'b1;
    @(posedge clock);
    #1;
    `CHK({addr_trap, access_fault, rvalid}, 3'b000)
    rst <= 1'b0;
    // the first request after that reset traps afresh
    issue('{0,1,0,0,0,16'h0901,0,0,1});
    #1;
    `CHK(access_fault, 1'b1)
    @(posedge clock);
    #1;
    `CHK({addr_trap, rdata}, {1'b1, 16'h55b2})
    give_verdict();
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
endmodule
